// ### hdl/rmd_pkg.sv
// Constants, types and shared decode functions for the register/memory
// instruction decoder. Assumes an 8-bit opcode and a 16-bit address bus.
package rmd_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 2;
  localparam int CYC_W = 3;

  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] OPERAND_STEP = 16'h0001;

  // Opcode high nibble: addressing mode
  localparam logic [3:0] NIB_IMM = 4'hA;
  localparam logic [3:0] NIB_DIR = 4'hB;
  localparam logic [3:0] NIB_EXT = 4'hC;
  localparam logic [3:0] NIB_IX0 = 4'hF;
  localparam logic [3:0] NIB_IX1 = 4'hE;
  localparam logic [3:0] NIB_IX2 = 4'hD;

  // Opcode low nibble: operation
  localparam logic [3:0] NIB_SUB = 4'h0;
  localparam logic [3:0] NIB_COMPARE_ACC = 4'h1;
  localparam logic [3:0] NIB_SUB_BORROW = 4'h2;
  localparam logic [3:0] NIB_COMPARE_IDX = 4'h3;
  localparam logic [3:0] NIB_AND = 4'h4;
  localparam logic [3:0] NIB_BIT = 4'h5;
  localparam logic [3:0] NIB_LOAD_ACC = 4'h6;
  localparam logic [3:0] NIB_STORE_ACC = 4'h7;
  localparam logic [3:0] NIB_XOR = 4'h8;
  localparam logic [3:0] NIB_ADC = 4'h9;
  localparam logic [3:0] NIB_OR_ACC = 4'hA;
  localparam logic [3:0] NIB_ADD = 4'hB;
  localparam logic [3:0] NIB_JUMP = 4'hC;
  localparam logic [3:0] NIB_CALL = 4'hD;
  localparam logic [3:0] NIB_LOAD_IDX = 4'hE;
  localparam logic [3:0] NIB_STORE_IDX = 4'hF;

  // Instruction length in bytes per mode
  localparam logic [LEN_W-1:0] LEN_NONE = 2'h1;
  localparam logic [LEN_W-1:0] LEN_IMM = 2'h2;
  localparam logic [LEN_W-1:0] LEN_DIR = 2'h2;
  localparam logic [LEN_W-1:0] LEN_EXT = 2'h3;
  localparam logic [LEN_W-1:0] LEN_IX0 = 2'h1;
  localparam logic [LEN_W-1:0] LEN_IX1 = 2'h2;
  localparam logic [LEN_W-1:0] LEN_IX2 = 2'h3;

  // Base cycle counts per mode, with per-operation offsets
  localparam logic [CYC_W-1:0] CYC_IMM = 3'h2;
  localparam logic [CYC_W-1:0] CYC_DIR = 3'h3;
  localparam logic [CYC_W-1:0] CYC_EXT = 3'h4;
  localparam logic [CYC_W-1:0] CYC_IX0 = 3'h3;
  localparam logic [CYC_W-1:0] CYC_IX1 = 3'h4;
  localparam logic [CYC_W-1:0] CYC_IX2 = 3'h5;
  localparam logic [CYC_W-1:0] CYC_NONE = 3'h0;
  localparam logic [CYC_W-1:0] CYC_STORE_ADD = 3'h1;
  localparam logic [CYC_W-1:0] CYC_JUMP_SUB = 3'h1;
  localparam logic [CYC_W-1:0] CYC_CALL_ADD = 3'h2;

  typedef enum logic [2:0] {
    MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX0, MODE_IX1, MODE_IX2, MODE_NONE
  } rmd_mode_t;

  typedef enum logic [4:0] {
    OP_SUB, OP_COMPARE_ACC, OP_SUB_BORROW, OP_COMPARE_IDX, OP_AND, OP_BIT, OP_LOAD_ACC,
    OP_STORE_ACC, OP_XOR, OP_ADC, OP_OR_ACC, OP_ADD, OP_JUMP, OP_CALL, OP_LOAD_IDX,
    OP_STORE_IDX, OP_NONE
  } rmd_op_t;

  function automatic rmd_mode_t rmd_mode_of(input logic [3:0] nib);
    case (nib)
      NIB_IMM: rmd_mode_of = MODE_IMM;
      NIB_DIR: rmd_mode_of = MODE_DIR;
      NIB_EXT: rmd_mode_of = MODE_EXT;
      NIB_IX0: rmd_mode_of = MODE_IX0;
      NIB_IX1: rmd_mode_of = MODE_IX1;
      NIB_IX2: rmd_mode_of = MODE_IX2;
      default: rmd_mode_of = MODE_NONE;
    endcase
  endfunction

  function automatic logic [LEN_W-1:0] rmd_len_of(input rmd_mode_t m);
    case (m)
      MODE_IMM: rmd_len_of = LEN_IMM;
      MODE_DIR: rmd_len_of = LEN_DIR;
      MODE_EXT: rmd_len_of = LEN_EXT;
      MODE_IX0: rmd_len_of = LEN_IX0;
      MODE_IX1: rmd_len_of = LEN_IX1;
      MODE_IX2: rmd_len_of = LEN_IX2;
      default: rmd_len_of = LEN_NONE;
    endcase
  endfunction

endpackage

// ### hdl/rmd_op_table.sv
// Registered opcode table: operation, mode, length, cycles and write flags.
// Expects a synchronised reset and a load strobe on the same clock.
`timescale 1ns/100ps
module rmd_op_table
  import rmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] opcode,
  output rmd_op_t op_reg,
  output rmd_mode_t mode_reg,
  output logic [LEN_W-1:0] len_reg,
  output logic [CYC_W-1:0] cyc_reg,
  output logic legal_reg,
  output logic acc_wr_reg,
  output logic idx_wr_reg,
  output logic mem_wr_reg
);

  rmd_op_t op_next;
  rmd_mode_t mode_next;
  logic [LEN_W-1:0] len_next;
  logic [CYC_W-1:0] cyc_next;
  logic [CYC_W-1:0] base;
  logic legal_next;
  logic acc_wr_next;
  logic idx_wr_next;
  logic mem_wr_next;

  // Nibble order matches the enum order, so a cast does the decode
  always_comb
  begin
    op_next = op_reg;
    mode_next = mode_reg;
    len_next = len_reg;
    cyc_next = cyc_reg;
    legal_next = legal_reg;
    acc_wr_next = acc_wr_reg;
    idx_wr_next = idx_wr_reg;
    mem_wr_next = mem_wr_reg;
    base = CYC_NONE;
    if (load)
    begin
      mode_next = rmd_mode_of(opcode[7:4]);
      op_next = rmd_op_t'({1'b0, opcode[3:0]});
      len_next = rmd_len_of(mode_next);
      case (mode_next)
        MODE_IMM: base = CYC_IMM;
        MODE_DIR: base = CYC_DIR;
        MODE_EXT: base = CYC_EXT;
        MODE_IX0: base = CYC_IX0;
        MODE_IX1: base = CYC_IX1;
        MODE_IX2: base = CYC_IX2;
        default: base = CYC_NONE;
      endcase
      legal_next = (mode_next != MODE_NONE);
      // No immediate form for stores, jumps and calls
      if (mode_next == MODE_IMM && (op_next == OP_STORE_ACC || op_next == OP_STORE_IDX ||
          op_next == OP_JUMP || op_next == OP_CALL))
      begin
        legal_next = 1'b0;
      end
      case (op_next)
        OP_STORE_ACC, OP_STORE_IDX: cyc_next = base + CYC_STORE_ADD;
        OP_JUMP: cyc_next = base - CYC_JUMP_SUB;
        OP_CALL: cyc_next = base + CYC_CALL_ADD;
        default: cyc_next = base;
      endcase
      // Compares and bit test only set flags
      acc_wr_next = op_next inside {OP_SUB, OP_SUB_BORROW, OP_AND, OP_LOAD_ACC, OP_XOR,
                                    OP_ADC, OP_OR_ACC, OP_ADD};
      idx_wr_next = (op_next == OP_LOAD_IDX);
      mem_wr_next = (op_next == OP_STORE_ACC || op_next == OP_STORE_IDX);
      if (!legal_next)
      begin
        op_next = OP_NONE;
        cyc_next = CYC_NONE;
        acc_wr_next = 1'b0;
        idx_wr_next = 1'b0;
        mem_wr_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_reg <= OP_NONE;
      mode_reg <= MODE_NONE;
      len_reg <= LEN_NONE;
      cyc_reg <= CYC_NONE;
      legal_reg <= 1'b0;
      acc_wr_reg <= 1'b0;
      idx_wr_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
    end
    else
    begin
      op_reg <= op_next;
      mode_reg <= mode_next;
      len_reg <= len_next;
      cyc_reg <= cyc_next;
      legal_reg <= legal_next;
      acc_wr_reg <= acc_wr_next;
      idx_wr_reg <= idx_wr_next;
      mem_wr_reg <= mem_wr_next;
    end
  end

endmodule

// ### hdl/rmd_decoder.sv
// Decoder and effective-address unit for register/memory instructions.
// Request inputs come from CPU logic on core_clk; only rst_b is synchronised.
`timescale 1ns/100ps
module rmd_decoder
  import rmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic dec_req,
  input wire logic [7:0] dec_opcode,
  input wire logic [7:0] dec_byte1,
  input wire logic [7:0] dec_byte2,
  input wire logic [7:0] index_reg,
  input wire logic [ADDR_W-1:0] pc_in,
  output logic dec_done,
  output logic dec_legal,
  output rmd_op_t dec_op,
  output rmd_mode_t dec_mode,
  output logic [LEN_W-1:0] dec_len,
  output logic [CYC_W-1:0] dec_cycles,
  output logic acc_write,
  output logic index_write,
  output logic mem_write,
  output logic [ADDR_W-1:0] eff_addr,
  output logic [ADDR_W-1:0] pc_next
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n_int;
  logic done_reg;
  logic done_next;
  logic [ADDR_W-1:0] ea_reg;
  logic [ADDR_W-1:0] ea_next;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next_val;
  logic [8:0] sum_lo;
  logic [8:0] sum_lo2;
  logic [7:0] sum_hi;
  rmd_mode_t req_mode;
  logic req_form_ok;

  // Release of reset is synchronised; assertion is still immediate
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n_int = rst_sync_reg;

  rmd_op_table u_table (
    .core_clk(core_clk),
    .rst_n(rst_n_int),
    .load(dec_req),
    .opcode(dec_opcode),
    .op_reg(dec_op),
    .mode_reg(dec_mode),
    .len_reg(dec_len),
    .cyc_reg(dec_cycles),
    .legal_reg(dec_legal),
    .acc_wr_reg(acc_write),
    .idx_wr_reg(index_write),
    .mem_wr_reg(mem_write)
  );

  always_comb
  begin
    done_next = dec_req;
    ea_next = ea_reg;
    pc_next_val = pc_reg;
    req_mode = rmd_mode_of(dec_opcode[7:4]);
    sum_lo = {1'b0, index_reg} + {1'b0, dec_byte1};
    sum_lo2 = {1'b0, index_reg} + {1'b0, dec_byte2};
    sum_hi = dec_byte1 + {7'h00, sum_lo2[8]};
    // Immediate store, jump and call do not exist
    req_form_ok = !(req_mode == MODE_IMM && dec_opcode[3:0] inside {NIB_STORE_ACC,
                    NIB_STORE_IDX, NIB_JUMP, NIB_CALL});
    if (dec_req)
    begin
      // Illegal opcodes leave the PC where it was so the core can trap
      pc_next_val = pc_in;
      if (req_mode != MODE_NONE && req_form_ok)
      begin
        pc_next_val = pc_in + 16'(rmd_len_of(req_mode));
      end
      case (req_mode)
        MODE_IMM: ea_next = pc_in + OPERAND_STEP;
        MODE_DIR: ea_next = {ZERO_BYTE, dec_byte1};
        MODE_EXT: ea_next = {dec_byte1, dec_byte2};
        MODE_IX0: ea_next = {ZERO_BYTE, index_reg};
        MODE_IX1: ea_next = {7'h00, sum_lo};
        MODE_IX2: ea_next = {sum_hi, sum_lo2[7:0]};
        default: ea_next = ZERO_ADDR;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      done_reg <= 1'b0;
      ea_reg <= ZERO_ADDR;
      pc_reg <= ZERO_ADDR;
    end
    else
    begin
      done_reg <= done_next;
      ea_reg <= ea_next;
      pc_reg <= pc_next_val;
    end
  end

  assign dec_done = done_reg;
  assign eff_addr = ea_reg;
  assign pc_next = pc_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n_int);

  sequence s_req(logic [3:0] mode_nib, logic [3:0] op_nib);
    dec_req && dec_opcode[7:4] == mode_nib && dec_opcode[3:0] == op_nib;
  endsequence

  sequence s_req_mode(logic [3:0] mode_nib);
    dec_req && dec_opcode[7:4] == mode_nib;
  endsequence

  chk_done_after_req: assert property (dec_req |=> dec_done ##1 (dec_done == $past(dec_req)))
    else $error("done pulse does not track request");

  chk_adc_ix2_cycles: assert property (s_req(NIB_IX2, NIB_ADC) |=>
    dec_op == OP_ADC && dec_mode == MODE_IX2 && dec_cycles == CYC_IX2)
    else $error("add-with-carry 16-bit offset decode wrong");

  chk_borrow_ix0_len: assert property (s_req(NIB_IX0, NIB_SUB_BORROW) |=>
    dec_op == OP_SUB_BORROW && dec_len == LEN_IX0 && dec_cycles == CYC_IX0)
    else $error("subtract with borrow no-offset decode wrong");

  chk_xor_imm_decode: assert property (s_req(NIB_IMM, NIB_XOR) |=>
    dec_op == OP_XOR && acc_write && dec_legal)
    else $error("exclusive or immediate decode wrong");

  chk_compare_no_write: assert property (s_req(NIB_EXT, NIB_COMPARE_ACC) |=>
    dec_op == OP_COMPARE_ACC && !acc_write && dec_len == LEN_EXT && dec_cycles == CYC_EXT)
    else $error("compare extended decode wrong");

  chk_bit_keeps_acc: assert property (dec_req && dec_opcode[3:0] == NIB_BIT &&
    dec_opcode[7:4] == NIB_DIR |=> dec_op == OP_BIT && !acc_write && dec_cycles == CYC_DIR)
    else $error("bit test writes accumulator");

  chk_ext_address: assert property (s_req_mode(NIB_EXT) |=>
    eff_addr == {$past(dec_byte1), $past(dec_byte2)} &&
    pc_next == $past(pc_in) + 16'(LEN_EXT))
    else $error("extended address or PC wrong");

  chk_ix0_page_zero: assert property (s_req_mode(NIB_IX0) |=>
    eff_addr[15:8] == ZERO_BYTE && eff_addr[7:0] == $past(index_reg) &&
    pc_next == $past(pc_in) + 16'(LEN_IX0))
    else $error("no-offset indexed address wrong");

  chk_ix1_carry: assert property (s_req_mode(NIB_IX1) |=>
    eff_addr == 16'({1'b0, $past(index_reg)} + {1'b0, $past(dec_byte1)}) &&
    pc_next == $past(pc_in) + 16'(LEN_IX1))
    else $error("8-bit offset indexed address wrong");

  chk_ix2_sum: assert property (s_req_mode(NIB_IX2) |=>
    eff_addr == {$past(dec_byte1), $past(dec_byte2)} + 16'($past(index_reg)) &&
    pc_next == $past(pc_in) + 16'(LEN_IX2))
    else $error("16-bit offset indexed address wrong");

  chk_mode_nibble: assert property (s_req(NIB_IX1, NIB_LOAD_IDX) |=>
    dec_op == OP_LOAD_IDX && dec_mode == MODE_IX1 && index_write)
    else $error("nibble decode wrong");

  chk_store_no_imm: assert property (
    s_req(NIB_IMM, NIB_STORE_ACC) or s_req(NIB_IMM, NIB_CALL) |=>
    !dec_legal && !mem_write && pc_next == $past(pc_in))
    else $error("immediate store or call accepted");

  chk_imm_form_pc: assert property (
    s_req(NIB_IMM, NIB_STORE_IDX) or s_req(NIB_IMM, NIB_JUMP) |=>
    !dec_legal && dec_cycles == CYC_NONE && pc_next == $past(pc_in))
    else $error("immediate store or jump moved the PC");

  chk_jump_cycles: assert property (s_req(NIB_DIR, NIB_JUMP) |=>
    dec_op == OP_JUMP && dec_cycles == CYC_DIR - CYC_JUMP_SUB && !mem_write)
    else $error("jump cycle count wrong");

  chk_call_cycles: assert property (s_req(NIB_IX2, NIB_CALL) |=>
    dec_cycles == CYC_IX2 + CYC_CALL_ADD ##0 dec_legal)
    else $error("call cycle count wrong");

  chk_imm_operand: assert property (s_req(NIB_IMM, NIB_LOAD_ACC) |=>
    eff_addr == $past(pc_in) + OPERAND_STEP && dec_len == LEN_IMM && dec_cycles == CYC_IMM)
    else $error("immediate operand decode wrong");

endmodule

// ### dv/rmd_mem_model.sv
// Program and data memory seen by the decoder: operand bytes at PC+1, PC+2.
// Assumes the bench preloads bytes before a request reads them.
`timescale 1ns/100ps
module rmd_mem_model
  import rmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_b1,
  input wire logic [7:0] wr_b2,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [7:0] rd_b1,
  output logic [7:0] rd_b2
);
  logic [7:0] mem [0:65535];
  logic [7:0] noise = 8'h5A;
  always @(posedge core_clk)
  begin
    // Unselected bus never holds a stale byte
    noise <= noise + 8'h3B;
    if (wr_en)
    begin
      mem[wr_addr + OPERAND_STEP] <= wr_b1;
      mem[wr_addr + 16'h0002] <= wr_b2;
    end
  end
  assign rd_b1 = rd_en ? mem[rd_addr + OPERAND_STEP] : noise;
  assign rd_b2 = rd_en ? mem[rd_addr + 16'h0002] : ~noise;
endmodule

// ### dv/rmd_decoder_bench.sv
// Self-checking bench for the register/memory decoder.
// Assumes one 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/100ps
module rmd_decoder_bench;
  import rmd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic dec_req = 1'b0;
  logic [7:0] dec_opcode = 8'h00;
  logic [7:0] index_reg = 8'h00;
  logic [ADDR_W-1:0] pc_in = 16'h0000;
  logic wr_en = 1'b0;
  logic [ADDR_W-1:0] wr_addr = 16'h0000;
  logic [7:0] wr_b1 = 8'h00;
  logic [7:0] wr_b2 = 8'h00;
  logic [7:0] dec_byte1;
  logic [7:0] dec_byte2;
  logic dec_done, dec_legal, acc_write, index_write, mem_write;
  rmd_op_t dec_op;
  rmd_mode_t dec_mode;
  logic [LEN_W-1:0] dec_len;
  logic [CYC_W-1:0] dec_cycles;
  logic [ADDR_W-1:0] eff_addr, pc_next;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  rmd_mem_model u_rmd_mem_model (.core_clk(core_clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_b1(wr_b1), .wr_b2(wr_b2), .rd_en(dec_req), .rd_addr(pc_in), .rd_b1(dec_byte1),
    .rd_b2(dec_byte2));
  rmd_decoder u_rmd_decoder (.core_clk(core_clk), .rst_b(rst_b), .dec_req(dec_req),
    .dec_opcode(dec_opcode), .dec_byte1(dec_byte1), .dec_byte2(dec_byte2),
    .index_reg(index_reg), .pc_in(pc_in), .dec_done(dec_done), .dec_legal(dec_legal),
    .dec_op(dec_op), .dec_mode(dec_mode), .dec_len(dec_len), .dec_cycles(dec_cycles),
    .acc_write(acc_write), .index_write(index_write), .mem_write(mem_write),
    .eff_addr(eff_addr), .pc_next(pc_next));
  function automatic rmd_mode_t f_mode(input logic [7:0] op);
    case (op[7:4])
      4'hA: f_mode = MODE_IMM;
      4'hB: f_mode = MODE_DIR;
      4'hC: f_mode = MODE_EXT;
      4'hF: f_mode = MODE_IX0;
      4'hE: f_mode = MODE_IX1;
      4'hD: f_mode = MODE_IX2;
      default: f_mode = MODE_NONE;
    endcase
  endfunction
  function automatic logic f_legal(input logic [7:0] op);
    // No immediate form for stores, jump and call
    f_legal = f_mode(op) != MODE_NONE && !(op[7:4] == 4'hA && op[3:0] inside
      {4'h7, 4'hF, 4'hC, 4'hD});
  endfunction
  function automatic logic [LEN_W-1:0] f_len(input logic [7:0] op);
    case (f_mode(op))
      MODE_IMM, MODE_DIR, MODE_IX1: f_len = 2'h2;
      MODE_EXT, MODE_IX2: f_len = 2'h3;
      default: f_len = 2'h1;
    endcase
  endfunction
  function automatic logic [CYC_W-1:0] f_cyc(input logic [7:0] op);
    logic [CYC_W-1:0] b;
    case (f_mode(op))
      MODE_IMM: b = 3'h2;
      MODE_DIR, MODE_IX0: b = 3'h3;
      MODE_EXT, MODE_IX1: b = 3'h4;
      default: b = 3'h5;
    endcase
    if (op[3:0] == 4'h7 || op[3:0] == 4'hF)
      b = b + 3'h1;
    else if (op[3:0] == 4'hC)
      b = b - 3'h1;
    else if (op[3:0] == 4'hD)
      b = b + 3'h2;
    f_cyc = f_legal(op) ? b : 3'h0;
  endfunction
  function automatic logic [15:0] f_ea(input logic [7:0] op, input logic [7:0] b1,
    input logic [7:0] b2, input logic [7:0] x, input logic [15:0] pc);
    case (f_mode(op))
      MODE_IMM: f_ea = pc + 16'h0001;
      MODE_DIR: f_ea = {8'h00, b1};
      MODE_EXT: f_ea = {b1, b2};
      MODE_IX0: f_ea = {8'h00, x};
      MODE_IX1: f_ea = {8'h00, x} + {8'h00, b1};
      MODE_IX2: f_ea = {b1, b2} + {8'h00, x};
      default: f_ea = 16'h0000;
    endcase
  endfunction
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_out(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
    input logic [7:0] x, input logic [15:0] pc);
    logic lg;
    lg = f_legal(op);
    chk("done", 16'h0001, {15'h0, dec_done});
    chk("legal", {15'h0, lg}, {15'h0, dec_legal});
    chk("op", lg ? {12'h0, op[3:0]} : 16'(OP_NONE), 16'(dec_op));
    chk("mode", 16'(f_mode(op)), 16'(dec_mode));
    chk("len", {14'h0, f_len(op)}, {14'h0, dec_len});
    chk("cycles", {13'h0, f_cyc(op)}, {13'h0, dec_cycles});
    chk("acc_wr", {15'h0, lg && op[3:0] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'hA,
      4'hB}}, {15'h0, acc_write});
    chk("idx_wr", {15'h0, lg && op[3:0] == 4'hE}, {15'h0, index_write});
    chk("mem_wr", {15'h0, lg && op[3:0] inside {4'h7, 4'hF}}, {15'h0, mem_write});
    chk("eff_addr", f_ea(op, b1, b2, x, pc), eff_addr);
    chk("pc_next", lg ? pc + {14'h0, f_len(op)} : pc, pc_next);
  endtask
  task automatic preload(input logic [15:0] pc, input logic [7:0] b1, input logic [7:0] b2);
    @(negedge core_clk);
    wr_en = 1'b1;
    wr_addr = pc;
    wr_b1 = b1;
    wr_b2 = b2;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask
  task automatic present(input logic [7:0] op, input logic [7:0] x, input logic [15:0] pc);
    dec_req = 1'b1;
    dec_opcode = op;
    index_reg = x;
    pc_in = pc;
  endtask
  task automatic run_op(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
    input logic [7:0] x, input logic [15:0] pc);
    preload(pc, b1, b2);
    present(op, x, pc);
    @(negedge core_clk);
    dec_req = 1'b0;
    check_out(op, b1, b2, x, pc);
    @(negedge core_clk);
    chk("done_low", 16'h0000, {15'h0, dec_done});
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  logic [3:0] hi_tab [6] = '{4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD};
  initial
  begin
    void'($urandom(32'h7fa650e0));
    repeat (3) @(negedge core_clk);
    chk("rst_len", 16'h0001, {14'h0, dec_len});
    chk("rst_ea", 16'h0000, eff_addr);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    run_op(8'hD9, 8'h12, 8'hF0, 8'h20, 16'h0100);
    foreach (hi_tab[m])
      for (int lo = 0; lo < 16; lo++)
        run_op({hi_tab[m], 4'(lo)}, 8'($urandom), 8'($urandom), 8'($urandom),
          16'($urandom));
    // Carry and boundary corners
    run_op(8'hE9, 8'hFF, 8'h00, 8'hFF, 16'h2000);
    run_op(8'hE2, 8'h01, 8'h00, 8'hFF, 16'h2000);
    run_op(8'hD8, 8'hFF, 8'hFF, 8'hFF, 16'hFFFD);
    run_op(8'hD1, 8'h00, 8'hFF, 8'h01, 16'h3000);
    run_op(8'hF5, 8'hAA, 8'h55, 8'hFF, 16'hFFFF);
    run_op(8'hC2, 8'hFF, 8'h01, 8'h33, 16'h1234);
    run_op(8'h9B, 8'h11, 8'h22, 8'h33, 16'h4000);
    run_op(8'hAC, 8'h11, 8'h22, 8'h33, 16'h4100);
    repeat (300)
      run_op(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom));
    // Back-to-back requests
    preload(16'h0500, 8'h80, 8'h81);
    preload(16'h0600, 8'h90, 8'h91);
    present(8'hC8, 8'h07, 16'h0500);
    @(negedge core_clk);
    present(8'hE7, 8'hF0, 16'h0600);
    check_out(8'hC8, 8'h80, 8'h81, 8'h07, 16'h0500);
    @(negedge core_clk);
    dec_req = 1'b0;
    check_out(8'hE7, 8'h90, 8'h91, 8'hF0, 16'h0600);
    @(negedge core_clk);
    complete_run();
  end
endmodule
